// ===== scp_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * system clock multiplier control block.
 * Assumes it is included by bare name from the lock detector, the control block and the bench.
 */
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define SCP_IDX_PLL_CTRL 12'h100
`define SCP_IDX_NOM_PERIOD 12'h103
`define SCP_IDX_STAB_TIMER 12'h106
`define SCP_IDX_CAL_SYNC 12'hA02
`define SCP_IDX_STATUS 12'hD01
`define SCP_IDX_IRQ_MON 12'hD02
`define SCP_IDX_IN_DIV 12'hF00
`define SCP_IDX_FB_DIV 12'hF01
`define SCP_IDX_IRQ_MASK 12'hF02
`define SCP_IDX_PLL_EN 12'hF03

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SCP_CTRL_LDSEL_LO 0
`define SCP_CTRL_LD_DIS 2
`define SCP_CTRL_CPCUR_LO 3
`define SCP_CTRL_CP_MAN 6
`define SCP_CTRL_EXT_LF 7
`define SCP_CTRL_RESET 8'h18
`define SCP_CAL_BIT 0
`define SCP_ST_CAL_BUSY 1
`define SCP_ST_LOCK 0
`define SCP_ST_STABLE 4
`define SCP_FB_MIN 8'h06
`define SCP_FB_MAX 8'hFF
`define SCP_FB_RESET 8'h28
`define SCP_CPCUR_RESET 3'h3

// ****************************************************************
// Timing counts.
// ****************************************************************
`define SCP_CLK_MHZ 25
`define SCP_MS_US 1000
`define SCP_MS_CYCLES (`SCP_CLK_MHZ * `SCP_MS_US)
`define SCP_CAL_CYCLES 64

`endif

// ===== scp_pkg.sv
/*
 * Types of the system clock multiplier control block.
 * Assumes scp_defines.svh lies in the same folder.
 */
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_CAL_IDLE = 2'b00,
        SCP_CAL_ARMED = 2'b01,
        SCP_CAL_RUN = 2'b10
    } scp_cal_e;
    typedef logic [31:0] scp_word_t;
endpackage : scp_pkg

// ===== scp_lock_detect.sv
/*
 * Lock detector: counts consecutive in-phase phase detector samples.
 * Assumes sample inputs are already synchronised to clk.
 */
`timescale 1ns/1ns
`include "scp_defines.svh"
module scp_lock_detect #(
    parameter int CNT_W = 11
) (
    // Clock and control.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic disable_det,
    input wire logic [1:0] sel,
    // Phase detector samples.
    input wire logic sample_valid,
    input wire logic in_phase,
    // Result.
    output logic locked
);
    import scp_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic locked;
    } scp_ld_s;

    scp_ld_s st_q;
    scp_ld_s st_d;
    logic [CNT_W-1:0] need;

    always_comb begin
        need = CNT_W'(128) << sel;
        st_d = st_q;
        if (disable_det) begin
            st_d.cnt = '0;
            st_d.locked = 1'b0;
        end else if (sample_valid) begin
            if (!in_phase) begin
                st_d.cnt = '0;
                st_d.locked = 1'b0;
            end else if (!st_q.locked) begin
                st_d.cnt = st_q.cnt + CNT_W'(1);
                if (st_d.cnt >= need) begin
                    st_d.locked = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign locked = st_q.locked;

    property p_ld_lose;
        @(posedge clk) disable iff (reset)
        (ce && sample_valid && !in_phase) |=> !locked;
    endproperty
    a_ld_lose: assert property (p_ld_lose) else $error("lock kept after bad sample");

    property p_ld_off;
        @(posedge clk) disable iff (reset)
        (ce && disable_det) |=> !locked;
    endproperty
    a_ld_off: assert property (p_ld_off) else $error("lock while disabled");
endmodule : scp_lock_detect

// ===== scp_pll_ctrl.sv
/*
 * System clock multiplier control: registers over AXI4-Lite, lock detect,
 * charge pump selection, stability timer and oscillator calibration start.
 * Assumes the analog phase detector samples and clock presence come from
 * outside the clk domain and are synchronised here.
 */
// The AXI4-Lite slave port was chosen for this implementation.
//
// Function
// - input divider ratio 1, 2, 4 or 8
// - feedback divider accepts values 6 to 255
// - control bit 2 disables lock detector
// - lock after 128/256/512/1024 in-phase samples
// - automatic pump current from feedback divider
// - manual pump current 125 to 1000 uA
// - control bit 7 selects external loop filter
// - 20-bit millisecond timer, zero times out now
// - enabled PLL: timer starts at lock
// - disabled PLL: timer starts at disable
// - timer expiry in status bit 4, pins
// - calibration starts after set then clear, with input clock present
// - calibration busy in status and monitor bit 1
// - reference monitors held off until stable
`timescale 1ns/1ns
`include "scp_defines.svh"
module scp_pll_ctrl #(
    parameter int MS_CYCLES = `SCP_MS_CYCLES,
    parameter int CAL_CYCLES = `SCP_CAL_CYCLES
) (
    // Clock, reset, enable.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // AXI4-Lite slave.
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire scp_pkg::scp_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output scp_pkg::scp_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog side inputs.
    input wire logic pfd_sample,
    input wire logic pfd_in_phase,
    input wire logic sys_clock_input_present,
    // Analog side controls.
    output logic [1:0] in_div_sel,
    output logic [7:0] fb_div,
    output logic [2:0] cp_current,
    output logic ext_loop_filter,
    output logic tank_oscillator_cal,
    output logic [20:0] nominal_period,
    // Status outputs.
    output logic pll_locked,
    output logic pll_stable,
    output logic ref_monitor_enable
);
    import scp_pkg::*;

    typedef struct packed {
        logic aw_got;
        logic [13:0] awaddr;
        logic w_got;
        scp_word_t wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        scp_word_t rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [20:0] nom;
        logic [19:0] stab;
        logic [7:0] cal_reg;
        logic [1:0] in_div;
        logic [7:0] fb;
        logic [7:0] mask;
        logic pll_en;
        scp_cal_e cal_st;
        logic [15:0] cal_cnt;
        logic tmr_run;
        logic tmr_done;
        logic [19:0] ms_left;
        logic [24:0] sub_cnt;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
    } scp_top_s;

    scp_top_s st_q;
    scp_top_s st_d;
    logic locked;
    logic pll_dis_evt;
    logic wr_go;
    logic [7:0] status;
    logic [2:0] auto_cp;

    // ****************************************************************
    // Lock detector.
    // ****************************************************************
    scp_lock_detect u_ld (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .disable_det(st_q.ctrl[`SCP_CTRL_LD_DIS] || !st_q.pll_en),
        .sel(st_q.ctrl[`SCP_CTRL_LDSEL_LO +: 2]),
        .sample_valid(st_q.sync_b[0]),
        .in_phase(st_q.sync_b[1]),
        .locked(locked)
    );

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        // Two-stage synchronisers for analog inputs.
        st_d.sync_a = {sys_clock_input_present, pfd_in_phase, pfd_sample};
        st_d.sync_b = st_q.sync_a;
        wr_go = st_q.aw_got && st_q.w_got && !st_q.bvalid;
        pll_dis_evt = 1'b0;
        if (s_axi_awvalid && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = 2'h0;
            if (st_q.awaddr[13:2] == `SCP_IDX_PLL_CTRL && st_q.wstrb[0]) begin
                st_d.ctrl = st_q.wdata[7:0];
            end else if (st_q.awaddr[13:2] == `SCP_IDX_NOM_PERIOD && st_q.wstrb[0]) begin
                st_d.nom = st_q.wdata[20:0];
            end else if (st_q.awaddr[13:2] == `SCP_IDX_STAB_TIMER && st_q.wstrb[0]) begin
                st_d.stab = st_q.wdata[19:0];
            end else if (st_q.awaddr[13:2] == `SCP_IDX_CAL_SYNC && st_q.wstrb[0]) begin
                st_d.cal_reg = st_q.wdata[7:0];
            end else if (st_q.awaddr[13:2] == `SCP_IDX_IN_DIV && st_q.wstrb[0]) begin
                st_d.in_div = st_q.wdata[1:0];
            end else if (st_q.awaddr[13:2] == `SCP_IDX_FB_DIV && st_q.wstrb[0]) begin
                if (st_q.wdata[7:0] >= `SCP_FB_MIN) begin
                    st_d.fb = st_q.wdata[7:0];
                end else begin
                    st_d.bresp = 2'h2;
                end
            end else if (st_q.awaddr[13:2] == `SCP_IDX_IRQ_MASK && st_q.wstrb[0]) begin
                st_d.mask = st_q.wdata[7:0];
            end else if (st_q.awaddr[13:2] == `SCP_IDX_PLL_EN && st_q.wstrb[0]) begin
                st_d.pll_en = st_q.wdata[0];
                pll_dis_evt = st_q.pll_en && !st_q.wdata[0];
            end else begin
                st_d.bresp = 2'h2;
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Read channel.
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = 2'h0;
            st_d.rdata = '0;
            if (s_axi_araddr[13:2] == `SCP_IDX_PLL_CTRL) begin
                st_d.rdata[7:0] = st_q.ctrl;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_NOM_PERIOD) begin
                st_d.rdata[20:0] = st_q.nom;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_STAB_TIMER) begin
                st_d.rdata[19:0] = st_q.stab;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_CAL_SYNC) begin
                st_d.rdata[7:0] = st_q.cal_reg;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_STATUS) begin
                st_d.rdata[7:0] = status;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_IRQ_MON) begin
                st_d.rdata[7:0] = status & st_q.mask;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_IN_DIV) begin
                st_d.rdata[1:0] = st_q.in_div;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_FB_DIV) begin
                st_d.rdata[7:0] = st_q.fb;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_IRQ_MASK) begin
                st_d.rdata[7:0] = st_q.mask;
            end else if (s_axi_araddr[13:2] == `SCP_IDX_PLL_EN) begin
                st_d.rdata[0] = st_q.pll_en;
            end else begin
                st_d.rresp = 2'h2;
            end
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        // Calibration: armed by setting the bit, started once it is clear and the input clock is present.
        case (st_q.cal_st)
            SCP_CAL_IDLE: begin
                if (st_q.cal_reg[`SCP_CAL_BIT]) begin
                    st_d.cal_st = SCP_CAL_ARMED;
                end
            end
            SCP_CAL_ARMED: begin
                if (!st_q.cal_reg[`SCP_CAL_BIT] && st_q.sync_b[2]) begin
                    st_d.cal_st = SCP_CAL_RUN;
                    st_d.cal_cnt = 16'(CAL_CYCLES);
                end
            end
            SCP_CAL_RUN: begin
                st_d.cal_cnt = st_q.cal_cnt - 16'h0001;
                if (st_q.cal_cnt <= 16'h0001) begin
                    st_d.cal_st = SCP_CAL_IDLE;
                end
            end
            default: begin
                st_d.cal_st = SCP_CAL_IDLE;
            end
        endcase
        // Stability timer.
        if (st_q.stab == 20'h00000) begin
            st_d.tmr_run = 1'b0;
            st_d.tmr_done = 1'b1;
        end else if (pll_dis_evt || (st_q.pll_en && locked && !st_q.tmr_run
                && !st_q.tmr_done)) begin
            st_d.tmr_run = 1'b1;
            st_d.tmr_done = 1'b0;
            st_d.ms_left = st_q.stab;
            st_d.sub_cnt = 25'(MS_CYCLES - 1);
        end else if (st_q.tmr_run) begin
            if (st_q.sub_cnt != 25'h0000000) begin
                st_d.sub_cnt = st_q.sub_cnt - 25'h0000001;
            end else if (st_q.ms_left <= 20'h00001) begin
                st_d.tmr_run = 1'b0;
                st_d.tmr_done = 1'b1;
            end else begin
                st_d.ms_left = st_q.ms_left - 20'h00001;
                st_d.sub_cnt = 25'(MS_CYCLES - 1);
            end
        end
        if (wr_go && st_q.awaddr[13:2] == `SCP_IDX_STAB_TIMER && st_q.wstrb[0]
                && st_q.wdata[19:0] != 20'h00000) begin
            st_d.tmr_done = 1'b0;
            st_d.tmr_run = 1'b0;
        end
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
            st_q.ctrl <= `SCP_CTRL_RESET;
            st_q.fb <= `SCP_FB_RESET;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    always_comb begin
        auto_cp = (st_q.fb > 8'h80) ? 3'h7 : (st_q.fb > 8'h40) ? 3'h5 : `SCP_CPCUR_RESET;
        status = '0;
        status[`SCP_ST_LOCK] = locked;
        status[`SCP_ST_CAL_BUSY] = (st_q.cal_st == SCP_CAL_RUN);
        status[`SCP_ST_STABLE] = st_q.tmr_done;
    end

    assign s_axi_awready = !st_q.aw_got;
    assign s_axi_wready = !st_q.w_got;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign in_div_sel = st_q.in_div;
    assign fb_div = st_q.fb;
    // Manual field used only in manual mode.
    assign cp_current = st_q.ctrl[`SCP_CTRL_CP_MAN] ?
        st_q.ctrl[`SCP_CTRL_CPCUR_LO +: 3] : auto_cp;
    assign ext_loop_filter = st_q.ctrl[`SCP_CTRL_EXT_LF];
    assign tank_oscillator_cal = (st_q.cal_st == SCP_CAL_RUN);
    assign nominal_period = st_q.nom;
    assign pll_locked = locked;
    assign pll_stable = st_q.tmr_done;
    assign ref_monitor_enable = st_q.tmr_done;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_zero_done;
        @(posedge clk) disable iff (reset)
        (ce && st_q.stab == 20'h00000) ##1 (st_q.stab == 20'h00000) |-> pll_stable;
    endproperty
    a_zero_done: assert property (p_zero_done) else $error("zero timer not done");

    property p_mon_gate;
        @(posedge clk) disable iff (reset)
        ref_monitor_enable == pll_stable;
    endproperty
    a_mon_gate: assert property (p_mon_gate) else $error("monitors on early");

    property p_cp_manual;
        @(posedge clk) disable iff (reset)
        st_q.ctrl[`SCP_CTRL_CP_MAN] |-> cp_current == st_q.ctrl[5:3];
    endproperty
    a_cp_manual: assert property (p_cp_manual) else $error("manual current wrong");

    property p_cp_auto;
        @(posedge clk) disable iff (reset)
        (!st_q.ctrl[`SCP_CTRL_CP_MAN] && $changed(st_q.ctrl[5:3]) && $stable(st_q.fb)
            && $stable(st_q.ctrl[`SCP_CTRL_CP_MAN]))
            |-> $stable(cp_current);
    endproperty
    a_cp_auto: assert property (p_cp_auto) else $error("auto current follows field");

    property p_fb_range;
        @(posedge clk) disable iff (reset)
        fb_div >= `SCP_FB_MIN;
    endproperty
    a_fb_range: assert property (p_fb_range) else $error("feedback below 6");

    sequence s_cal_armed;
        st_q.cal_st == SCP_CAL_ARMED && !st_q.cal_reg[0] && st_q.sync_b[2] && ce;
    endsequence
    property p_cal_start;
        @(posedge clk) disable iff (reset)
        s_cal_armed |=> status[1] && tank_oscillator_cal;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration not started");

    property p_stable_bit;
        @(posedge clk) disable iff (reset)
        status[4] == pll_stable;
    endproperty
    a_stable_bit: assert property (p_stable_bit) else $error("status 4 mismatch");

    property p_tmr_lock_start;
        @(posedge clk) disable iff (reset)
        (ce && st_q.stab != 0 && st_q.pll_en && locked && !st_q.tmr_run && !st_q.tmr_done
            && !wr_go) |=> st_q.tmr_run;
    endproperty
    a_tmr_lock_start: assert property (p_tmr_lock_start) else $error("no start at lock");

    property p_tmr_dis_start;
        @(posedge clk) disable iff (reset)
        (ce && pll_dis_evt && st_q.stab != 0) |=> st_q.tmr_run && !pll_stable;
    endproperty
    a_tmr_dis_start: assert property (p_tmr_dis_start) else $error("no start at disable");
endmodule : scp_pll_ctrl

// ===== scp_ref_model.sv
/*
 * Reference oscillator model at the far side of the multiplier control block.
 * Assumes its tasks are called just after a rising clk edge.
 */
`timescale 1ns/1ns
module scp_ref_model (
    // Clock.
    input wire logic clk,
    // Phase detector and presence lines.
    output logic pfd_sample,
    output logic pfd_in_phase,
    output logic sys_clock_input_present
);
    // ****************************************
    // Sample stream.
    // ****************************************
    initial begin
        pfd_sample = 1'b0;
        pfd_in_phase = 1'b0;
        sys_clock_input_present = 1'b1;
    end
    // Issues n samples of one phase; the phase line flips between samples.
    task automatic burst(input int n, input logic ph);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            pfd_sample <= 1'b1;
            pfd_in_phase <= ph;
            @(posedge clk);
            pfd_sample <= 1'b0;
            pfd_in_phase <= ~ph;
        end
    endtask : burst
    // Removes or restores the input clock.
    task automatic set_present(input logic p);
        sys_clock_input_present <= p;
    endtask : set_present
endmodule : scp_ref_model

// ===== system_clock_pll_control_bench.sv
/*
 * Self-checking bench of the system clock multiplier control block.
 * Assumes scp_defines.svh, scp_pkg, scp_pll_ctrl and scp_ref_model are compiled first.
 */
`timescale 1ns/1ns
`include "scp_defines.svh"
module system_clock_pll_control_bench;
    import scp_pkg::*;
    typedef struct {
        logic [11:0] addr;
        scp_word_t data;
        logic [1:0] resp;
        logic [5:0] outs;
    } scp_row_s;
    // ****************************************
    // Signals and design.
    // ****************************************
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
    logic [20:0] nom_period;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    scp_word_t wdata = 32'h0, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, pfd_s, pfd_p, present;
    logic [1:0] bresp, rresp, resp, in_div_sel;
    logic [7:0] fb_div;
    logic [2:0] cp_current;
    logic ext_loop_filter, tank_oscillator_cal, pll_locked, pll_stable, ref_monitor_enable;
    int failures = 0, checks = 0, cycles = 0, n;
    // Each row: address, data, response, then {external filter, pump code, divider}.
    scp_row_s rows [20] = '{
        '{`SCP_IDX_IN_DIV, 32'h0, 2'h0, 6'h0C},
        '{`SCP_IDX_IN_DIV, 32'h1, 2'h0, 6'h0D},
        '{`SCP_IDX_IN_DIV, 32'h2, 2'h0, 6'h0E},
        '{`SCP_IDX_IN_DIV, 32'h3, 2'h0, 6'h0F},
        '{`SCP_IDX_FB_DIV, 32'h05, 2'h2, 6'h0F},
        '{`SCP_IDX_FB_DIV, 32'h81, 2'h0, 6'h1F},
        '{`SCP_IDX_FB_DIV, 32'h41, 2'h0, 6'h17},
        '{`SCP_IDX_FB_DIV, 32'h06, 2'h0, 6'h0F},
        '{`SCP_IDX_PLL_CTRL, 32'h20, 2'h0, 6'h0F},
        '{`SCP_IDX_PLL_CTRL, 32'h38, 2'h0, 6'h0F},
        '{`SCP_IDX_PLL_CTRL, 32'h40, 2'h0, 6'h03},
        '{`SCP_IDX_PLL_CTRL, 32'h48, 2'h0, 6'h07},
        '{`SCP_IDX_PLL_CTRL, 32'h50, 2'h0, 6'h0B},
        '{`SCP_IDX_PLL_CTRL, 32'h58, 2'h0, 6'h0F},
        '{`SCP_IDX_PLL_CTRL, 32'h60, 2'h0, 6'h13},
        '{`SCP_IDX_PLL_CTRL, 32'h68, 2'h0, 6'h17},
        '{`SCP_IDX_PLL_CTRL, 32'h70, 2'h0, 6'h1B},
        '{`SCP_IDX_PLL_CTRL, 32'h78, 2'h0, 6'h1F},
        '{`SCP_IDX_PLL_CTRL, 32'hE8, 2'h0, 6'h37},
        '{12'h200, 32'h0, 2'h2, 6'h37}};
    scp_pll_ctrl #(.MS_CYCLES(4), .CAL_CYCLES(16)) i_scp_pll_ctrl (
        .clk(clk), .reset(reset), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pfd_sample(pfd_s), .pfd_in_phase(pfd_p), .sys_clock_input_present(present),
        .in_div_sel(in_div_sel), .fb_div(fb_div), .cp_current(cp_current),
        .ext_loop_filter(ext_loop_filter), .tank_oscillator_cal(tank_oscillator_cal),
        .nominal_period(nom_period), .pll_locked(pll_locked), .pll_stable(pll_stable),
        .ref_monitor_enable(ref_monitor_enable));
    scp_ref_model i_scp_ref_model (.clk(clk), .pfd_sample(pfd_s), .pfd_in_phase(pfd_p),
        .sys_clock_input_present(present));
    // ****************************************
    // Tasks.
    // ****************************************
    task automatic chk(input string what, input scp_word_t got, input scp_word_t exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk("bus response", {30'h0, got}, {30'h0, exp});
    endtask : chk_resp
    task automatic axi_wr(input logic [11:0] a, input scp_word_t d);
        awaddr <= {a, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a);
        araddr <= {a, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
    endtask : axi_rd
    task automatic do_reset;
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : do_reset
    task automatic end_sim;
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // ****************************************
    // Clock, timeout and sequence.
    // ****************************************
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("Error at %0t ns: timeout", $time);
            end_sim();
        end
    end
    initial begin
        do_reset();
        chk("stable at reset", pll_stable, 1);
        chk("monitors at reset", ref_monitor_enable, 1);
        chk("feedback reset", fb_div, 8'h28);
        chk("auto pump", cp_current, 3);
        chk("internal filter", ext_loop_filter, 0);
        axi_rd(`SCP_IDX_PLL_CTRL);
        chk("control reset", rd, `SCP_CTRL_RESET);
        foreach (rows[i]) begin
            axi_wr(rows[i].addr, rows[i].data);
            chk_resp(resp, rows[i].resp);
            chk("outputs", {ext_loop_filter, cp_current, in_div_sel}, rows[i].outs);
        end
        axi_wr(`SCP_IDX_NOM_PERIOD, 32'h000F4240);
        chk("nominal period", nom_period, 21'h0F4240);
        axi_rd(`SCP_IDX_PLL_CTRL);
        chk("control readback", rd[7:0], 8'hE8);
        for (int s = 0; s < 4; s++) begin
            do_reset();
            axi_wr(`SCP_IDX_PLL_EN, 32'h1);
            axi_wr(`SCP_IDX_PLL_CTRL, 32'h20 + s);
            i_scp_ref_model.burst(64 << s, 1'b1);
            i_scp_ref_model.burst(1, 1'b0);
            i_scp_ref_model.burst((128 << s) - 1, 1'b1);
            repeat (8) @(posedge clk);
            chk("lock too early", pll_locked, 0);
            i_scp_ref_model.burst(1, 1'b1);
            for (n = 0; n < 10 && pll_locked !== 1'b1; n++) @(posedge clk);
            chk("lock count", pll_locked, 1);
        end
        do_reset();
        axi_wr(`SCP_IDX_STAB_TIMER, 32'h3);
        axi_wr(`SCP_IDX_PLL_EN, 32'h1);
        repeat (30) @(posedge clk);
        chk("stable before lock", pll_stable, 0);
        chk("monitors held", ref_monitor_enable, 0);
        i_scp_ref_model.burst(128, 1'b1);
        for (n = 0; n < 40 && pll_stable !== 1'b1; n++) @(posedge clk);
        chk("stable after lock", pll_stable, 1);
        chk("monitors released", ref_monitor_enable, 1);
        axi_rd(`SCP_IDX_STATUS);
        chk("status", rd & 32'h13, 32'h11);
        axi_wr(`SCP_IDX_PLL_EN, 32'h0);
        chk("timer at disable", pll_stable, 0);
        for (n = 0; n < 40 && pll_stable !== 1'b1; n++) @(posedge clk);
        chk("stable after disable", pll_stable, 1);
        do_reset();
        axi_wr(`SCP_IDX_STAB_TIMER, 32'h0);
        axi_wr(`SCP_IDX_PLL_EN, 32'h1);
        axi_wr(`SCP_IDX_PLL_CTRL, 32'h24);
        i_scp_ref_model.burst(200, 1'b1);
        repeat (8) @(posedge clk);
        chk("detector off", pll_locked, 0);
        axi_wr(`SCP_IDX_IRQ_MASK, 32'h2);
        axi_wr(`SCP_IDX_CAL_SYNC, 32'h1);
        repeat (4) @(posedge clk);
        chk("cal waits for clear", tank_oscillator_cal, 0);
        axi_wr(`SCP_IDX_CAL_SYNC, 32'h0);
        for (n = 0; n < 10 && tank_oscillator_cal !== 1'b1; n++) @(posedge clk);
        chk("cal start", tank_oscillator_cal, 1);
        axi_rd(`SCP_IDX_STATUS);
        chk("cal busy", rd[1], 1);
        axi_rd(`SCP_IDX_IRQ_MON);
        chk("cal monitor", rd[1], 1);
        for (n = 0; n < 60 && tank_oscillator_cal !== 1'b0; n++) @(posedge clk);
        axi_rd(`SCP_IDX_STATUS);
        chk("cal done", rd[1], 0);
        i_scp_ref_model.set_present(1'b0);
        repeat (4) @(posedge clk);
        axi_wr(`SCP_IDX_CAL_SYNC, 32'h1);
        axi_wr(`SCP_IDX_CAL_SYNC, 32'h0);
        repeat (20) @(posedge clk);
        chk("cal needs clock", tank_oscillator_cal, 0);
        end_sim();
    end
endmodule : system_clock_pll_control_bench
